// file: inc/trib_defines.svh
// Constants for the tributary select-protocol engine
`ifndef TRIB_DEFINES_SVH
`define TRIB_DEFINES_SVH

// Supervisory characters
`define CH_GROUP_ASSIGN  8'h01
`define CH_STX           8'h02
`define CH_ESC           8'h03
`define CH_ACK           8'h04
`define CH_NAK           8'h05
`define CH_BUSY          8'h06
`define CH_RESET         8'h07
`define CH_SERVICE_REQ   8'h08
`define CH_TRANSMIT_EN   8'h09

// Group assignment byte values
`define GRP_CLEAR_ALL    8'h00
`define GRP_JOIN_ALL     8'h80

// Address layout
`define ALL_CALL_ADDR    16'h8080
`define GROUP_HI_TAG     7'h40
`define ADDR_FLAG_BIT    7
`define ADDR_POLL_BIT    0

// Reset value of the membership table: all-call only
`define GROUPS_RESET     128'h1

// Character periods of silence tolerated inside a sequence
`define TIMEOUT_CHARS    6

`endif

// file: inc/trib_pkg.sv
// Types of the tributary select-protocol engine
package trib_pkg;

	// Protocol states, one-hot
	typedef enum logic [12:0] {
		ST_IDLE    = 13'h0001,
		ST_ACTIVE  = 13'h0002,
		ST_ADDR2   = 13'h0004,
		ST_SELECT  = 13'h0008,
		ST_GSEL    = 13'h0010,
		ST_RXCNT   = 13'h0020,
		ST_RXDATA  = 13'h0040,
		ST_RXSUM   = 13'h0080,
		ST_GRPWAIT = 13'h0100,
		ST_ESCMODE = 13'h0200,
		ST_TXCNT   = 13'h0400,
		ST_TXDATA  = 13'h0800,
		ST_TXSUM   = 13'h1000
	} state_e;

	// Complete state of the engine
	typedef struct packed {
		state_e         state;    // Protocol state
		logic           group_assign_char;      // Sequence runs under group select
		logic [8:0]     cnt;      // Bytes still to move
		logic [7:0]     sum;      // Running checksum
		logic [7:0]     addr_hi;  // First address byte
		logic [127:0]   groups;   // Group membership, bit 0 all-call
		logic [7:0]     tx_data;  // Byte offered to the channel
		logic           tx_full;  // Byte waiting for the channel
		logic           urx_v;    // User byte strobe
		logic [7:0]     urx_d;    // User byte
		logic           urx_cnt;  // User byte is the count byte
		logic           blk_ok;   // Good block strobe
		logic           blk_err;  // Failed block strobe
		logic           rst_flag; // Reset since last poll
		logic           exc_flag; // Exception since last poll/select
	} trib_s;

endpackage : trib_pkg

// file: rtl/trib_timeout.sv
// Character-period silence timer for open sequences
`timescale 1ns/10ps
`include "trib_defines.svh"

module trib_timeout #(
	parameter int TIMEOUT_CHARS = `TIMEOUT_CHARS
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic reset,
	// Control
	input  wire logic run,
	input  wire logic restart,
	input  wire logic char_tick,
	// Result
	output logic      expired
);
	localparam int CW = $clog2(TIMEOUT_CHARS + 2);

	// Refuse a limit the counter cannot serve
	if (TIMEOUT_CHARS < 1) begin : g_chk
		$error("TIMEOUT_CHARS must be at least 1");
	end

	// Timer state
	typedef struct packed {
		logic [CW-1:0] cnt; // Character periods seen
		logic          exp; // Expiry strobe
	} tmo_s;

	tmo_s q;
	tmo_s d;

	// Count ticks while open, restart on every byte
	always_comb begin
		d = q;
		d.exp = 1'b0;
		if (restart || !run) begin
			d.cnt = '0;
		end else if (char_tick) begin
			if (q.cnt == CW'(TIMEOUT_CHARS)) begin
				d.exp = 1'b1;
				d.cnt = '0;
			end else begin
				d.cnt = CW'(q.cnt + 1'b1);
			end
		end
	end

	// State register
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign expired = q.exp;

endmodule : trib_timeout

// file: rtl/tributary_select_protocol.sv
// Tributary supervisory-protocol engine: address, select, group select
// Function
// - Own select address enters select, other select addresses idle, polls stay active
// - Block: count, message bytes, checksum byte
// - Checksum is negated low byte of sum
// - Good block in select: send ACK, stay
// - Bad block in select: NAK, then idle
// - Silence beyond six characters in block: idle
// - Good block handed to user, block ready
// - Service request on poll; transmit enable sends block
// - Assignment byte clears, joins, adds or removes groups
// - Silence before assignment byte: drop, go idle
// - Reset clears groups except all-call
// - ESC in select: ACK, escape until BREAK
// - BREAK aborts everything, goes active at once
// - After reset idle until BREAK
// - Member group address enters group select
// - Good block in group select: silent, stay
// - Group error NAK then idle; silence idle
// - ESC in group select: escape until BREAK
// - Address bytes bit 7 set, bit 0 poll
// - Supervisory characters are fixed single bytes
`timescale 1ns/10ps
`include "trib_defines.svh"

module tributary_select_protocol #(
	parameter int TIMEOUT_CHARS = `TIMEOUT_CHARS
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             reset,
	// Configuration
	input  wire logic [15:0]      select_addr,
	// Channel receive side
	input  wire logic             rx_valid,
	input  wire logic [7:0]       rx_data,
	input  wire logic             rx_break,
	input  wire logic             char_tick,
	// Channel transmit side
	output logic                  tx_valid,
	output logic [7:0]            tx_data,
	input  wire logic             tx_ready,
	// User receive side
	output logic                  usr_rx_valid,
	output logic [7:0]            usr_rx_data,
	output logic                  usr_rx_count,
	output logic                  block_ready,
	output logic                  block_error,
	// User transmit side
	input  wire logic             usr_tx_valid,
	input  wire logic [7:0]       usr_tx_data,
	output logic                  usr_tx_ready,
	input  wire logic             msg_pending,
	input  wire logic             usr_busy,
	// Status
	output logic                  selected,
	output logic                  group_selected,
	output logic                  escape_mode,
	output trib_pkg::state_e      trib_state
);
	import trib_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Decoding helpers

	// Count byte to bytes to move; zero stands for 256
	function automatic logic [8:0] count_of(input logic [7:0] b);
		count_of = (b == 8'h00) ? 9'h100 : {1'b0, b};
	endfunction : count_of

	// States that receive a block
	function automatic logic is_rx_state(input state_e s);
		is_rx_state = (s == ST_RXCNT) || (s == ST_RXDATA) || (s == ST_RXSUM);
	endfunction : is_rx_state

	// States in which silence is timed
	function automatic logic is_open_state(input state_e s);
		is_open_state = is_rx_state(s) || (s == ST_ADDR2) || (s == ST_GRPWAIT);
	endfunction : is_open_state

	// Group select address: high byte 80h or 81h, select form
	function automatic logic is_group_addr(input logic [15:0] a);
		is_group_addr = (a[15:9] == `GROUP_HI_TAG) && !a[`ADDR_POLL_BIT];
	endfunction : is_group_addr

	////////////////////////////////////////////////////////////////////////
	// State and timer

	trib_s q;           // Registered state
	trib_s d;           // Next state
	logic  tmo_expired; // Silence too long
	logic  usr_take;    // User byte accepted
	logic [15:0] addr;  // Assembled address
	logic [6:0]  gnum;  // Group number of a group address
	logic [7:0]  poll_char; // Status answer to a poll

	// Silence timer, runs only while a sequence is open
	trib_timeout #(
		.TIMEOUT_CHARS (TIMEOUT_CHARS)
	) u_timeout (
		.mclk      (mclk),
		.reset     (reset),
		.run       (is_open_state(q.state)),
		.restart   (rx_valid),
		.char_tick (char_tick),
		.expired   (tmo_expired)
	);

	// Address, group number and poll status decode
	always_comb begin
		addr = {q.addr_hi, rx_data};
		gnum = {q.addr_hi[0], rx_data[6:1]};
		if (q.rst_flag) begin
			poll_char = `CH_RESET;       // Highest priority
		end else if (q.exc_flag) begin
			poll_char = `CH_NAK;
		end else if (usr_busy) begin
			poll_char = `CH_BUSY;
		end else if (msg_pending) begin
			poll_char = `CH_SERVICE_REQ;
		end else begin
			poll_char = `CH_ACK;
		end
	end

	// User transmit handshake: one byte per free channel slot
	assign usr_take = ((q.state == ST_TXCNT) || (q.state == ST_TXDATA))
		&& !q.tx_full && !rx_break;
	assign usr_tx_ready = usr_take;

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		d = q;
		d.urx_v   = 1'b0;
		d.urx_cnt = 1'b0;
		d.blk_ok  = 1'b0;
		d.blk_err = 1'b0;
		// Channel took the pending byte
		if (q.tx_full && tx_ready) begin
			d.tx_full = 1'b0;
		end
		if (rx_break) begin
			// Abort any sequence and any pending byte
			d.state   = ST_ACTIVE;
			d.tx_full = 1'b0;
			d.group_assign_char     = 1'b0;
		end else if (tmo_expired) begin
			// Silence inside address, block or assignment
			d.state    = ST_IDLE;
			d.exc_flag = 1'b1;
			d.blk_err  = is_rx_state(q.state);
		end else begin
			case (q.state)
				ST_IDLE: begin
					// Deaf until BREAK
					d.state = ST_IDLE;
				end
				ST_ACTIVE: if (rx_valid) begin
					if (rx_data[`ADDR_FLAG_BIT]) begin
						d.addr_hi = rx_data;
						d.state   = ST_ADDR2;
					end else begin
						d.state    = ST_IDLE; // Undefined byte
						d.exc_flag = 1'b1;
					end
				end
				ST_ADDR2: if (rx_valid) begin
					if (!rx_data[`ADDR_FLAG_BIT]) begin
						d.state    = ST_IDLE;
						d.exc_flag = 1'b1;
					end else if (addr == select_addr) begin
						d.state    = ST_SELECT;
						d.group_assign_char      = 1'b0;
						d.exc_flag = 1'b0;
					end else if (addr == {select_addr[15:1], 1'b1}) begin
						// Poll: one status byte, back to active
						d.tx_data  = poll_char;
						d.tx_full  = 1'b1;
						d.rst_flag = 1'b0;
						d.exc_flag = 1'b0;
						d.state    = ST_ACTIVE;
					end else if (is_group_addr(addr)) begin
						if (q.groups[gnum]) begin
							d.state = ST_GSEL;
							d.group_assign_char   = 1'b1;
						end else begin
							d.state = ST_IDLE;
						end
					end else if (!rx_data[`ADDR_POLL_BIT]) begin
						d.state = ST_IDLE;
					end else begin
						d.state = ST_ACTIVE; // Other poll
					end
				end
				ST_SELECT, ST_GSEL: if (rx_valid) begin
					case (rx_data)
						`CH_STX: begin
							d.state = ST_RXCNT;
						end
						`CH_ESC: begin
							d.state = ST_ESCMODE;
							if (!q.group_assign_char) begin
								d.tx_data = `CH_ACK;
								d.tx_full = 1'b1;
							end
						end
						`CH_GROUP_ASSIGN: begin
							d.state = q.group_assign_char ? ST_IDLE : ST_GRPWAIT;
						end
						`CH_TRANSMIT_EN: begin
							d.state = q.group_assign_char ? ST_IDLE : ST_TXCNT;
						end
						`CH_ACK, `CH_NAK: begin
							// Controller answer to a block we sent; stay put
							d.state = q.state;
						end
						default: begin
							d.state    = ST_IDLE;
							d.exc_flag = 1'b1;
						end
					endcase
				end
				ST_RXCNT: if (rx_valid) begin
					// Count byte opens the sum and goes to the user
					d.cnt     = count_of(rx_data);
					d.sum     = rx_data;
					d.urx_v   = 1'b1;
					d.urx_d   = rx_data;
					d.urx_cnt = 1'b1;
					d.state   = ST_RXDATA;
				end
				ST_RXDATA: if (rx_valid) begin
					d.sum   = 8'(q.sum + rx_data);
					d.cnt   = 9'(q.cnt - 9'h001);
					d.urx_v = 1'b1;
					d.urx_d = rx_data;
					if (q.cnt == 9'h001) begin
						d.state = ST_RXSUM;
					end
				end
				ST_RXSUM: if (rx_valid) begin
					if (8'(q.sum + rx_data) == 8'h00) begin
						d.blk_ok = 1'b1;
						if (q.group_assign_char) begin
							d.state = ST_GSEL;
						end else begin
							d.tx_data = `CH_ACK;
							d.tx_full = 1'b1;
							d.state   = ST_SELECT;
						end
					end else begin
						d.tx_data  = `CH_NAK;
						d.tx_full  = 1'b1;
						d.blk_err  = 1'b1;
						d.exc_flag = 1'b1;
						d.state    = ST_IDLE;
					end
				end
				ST_GRPWAIT: if (rx_valid) begin
					if (rx_data == `GRP_CLEAR_ALL) begin
						d.groups = `GROUPS_RESET;
					end else if (rx_data == `GRP_JOIN_ALL) begin
						d.groups = '1;
					end else begin
						d.groups[rx_data[6:0]] = rx_data[7];
					end
					d.groups[0] = 1'b1;
					d.tx_data   = `CH_ACK;
					d.tx_full   = 1'b1;
					d.state     = ST_SELECT;
				end
				ST_ESCMODE: if (rx_valid) begin
					// Custom traffic goes to the user untouched
					d.urx_v = 1'b1;
					d.urx_d = rx_data;
				end
				ST_TXCNT: if (usr_take && usr_tx_valid) begin
					d.tx_data = usr_tx_data;
					d.tx_full = 1'b1;
					d.cnt     = count_of(usr_tx_data);
					d.sum     = usr_tx_data;
					d.state   = ST_TXDATA;
				end
				ST_TXDATA: if (usr_take && usr_tx_valid) begin
					d.tx_data = usr_tx_data;
					d.tx_full = 1'b1;
					d.sum     = 8'(q.sum + usr_tx_data);
					d.cnt     = 9'(q.cnt - 9'h001);
					if (q.cnt == 9'h001) begin
						d.state = ST_TXSUM;
					end
				end
				ST_TXSUM: if (!q.tx_full) begin
					d.tx_data = 8'(8'h00 - q.sum);
					d.tx_full = 1'b1;
					d.state   = ST_SELECT;
				end
				default: begin
					d.state = ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			q          <= '0;
			q.state    <= ST_IDLE;
			q.groups   <= `GROUPS_RESET;
			q.rst_flag <= 1'b1;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign tx_valid       = q.tx_full;
	assign tx_data        = q.tx_data;
	assign usr_rx_valid   = q.urx_v;
	assign usr_rx_data    = q.urx_d;
	assign usr_rx_count   = q.urx_cnt;
	assign block_ready    = q.blk_ok;
	assign block_error    = q.blk_err;
	assign selected       = (q.state != ST_IDLE) && (q.state != ST_ACTIVE)
		&& (q.state != ST_ADDR2) && !q.group_assign_char;
	assign group_selected = (q.state != ST_IDLE) && q.group_assign_char;
	assign escape_mode    = (q.state == ST_ESCMODE);
	assign trib_state     = q.state;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	brk_to_active_a: assert property (rx_break |=> trib_state == ST_ACTIVE && !tx_valid)
		else $error("BREAK did not force active");
	idle_deaf_a: assert property (trib_state == ST_IDLE && !rx_break |=> trib_state == ST_IDLE)
		else $error("left idle without BREAK");
	allcall_kept_a: assert property (q.groups[0])
		else $error("all-call membership lost");
	sel_enter_a: assert property (trib_state == ST_ADDR2 && rx_valid && !rx_break && !tmo_expired
		&& addr == select_addr |=> trib_state == ST_SELECT)
		else $error("own select address not taken");
	good_ack_a: assert property (trib_state == ST_RXSUM && rx_valid && !rx_break && !tmo_expired
		&& !q.group_assign_char && 8'(q.sum + rx_data) == 8'h00
		|=> tx_valid && tx_data == `CH_ACK && block_ready && trib_state == ST_SELECT)
		else $error("good block not acknowledged");
	bad_nak_a: assert property (trib_state == ST_RXSUM && rx_valid && !rx_break && !tmo_expired
		&& 8'(q.sum + rx_data) != 8'h00
		|=> tx_valid && tx_data == `CH_NAK && block_error && trib_state == ST_IDLE)
		else $error("bad block not refused");
	grp_silent_a: assert property (trib_state == ST_RXSUM && rx_valid && !rx_break && !tmo_expired
		&& q.group_assign_char && 8'(q.sum + rx_data) == 8'h00
		|=> !tx_valid && trib_state == ST_GSEL)
		else $error("group block answered");
	tmo_idle_a: assert property (tmo_expired && !rx_break && is_rx_state(trib_state)
		|=> trib_state == ST_IDLE && block_error)
		else $error("timeout did not end block");
	blk_ready_a: assert property ($rose(block_ready) |-> $past(trib_state) == ST_RXSUM)
		else $error("block ready out of place");
	esc_ack_a: assert property (trib_state == ST_SELECT && rx_valid && rx_data == `CH_ESC
		&& !rx_break && !tmo_expired |=> escape_mode && tx_valid && tx_data == `CH_ACK)
		else $error("escape not acknowledged");
	grp_clear_a: assert property (trib_state == ST_GRPWAIT && rx_valid && rx_data == `GRP_CLEAR_ALL
		&& !rx_break && !tmo_expired |=> q.groups == `GROUPS_RESET)
		else $error("group clear failed");

	// Main scenarios
	good_block_c: cover property (block_ready && trib_state == ST_SELECT);
	group_block_c: cover property (block_ready && trib_state == ST_GSEL);
	escape_c: cover property (trib_state == ST_ESCMODE ##1 rx_break);
	tx_block_c: cover property (trib_state == ST_TXSUM ##1 trib_state == ST_SELECT);

endmodule : tributary_select_protocol

// file: testbench/bus_ctl_model.sv
// Bus controller model on the far side of the tributary channel
`timescale 1ns/10ps
`include "trib_defines.svh"

module bus_ctl_model #(
	parameter int CHAR = 8
) (
	// Clock
	input  wire logic       mclk,
	// Channel toward the tributary
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_break,
	output logic            char_tick,
	// Channel from the tributary
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	int   tick_cnt; // Character period divider
	int   stall;    // Cycles held off before a reply is taken
	logic grp_mode; // Group operation under way

	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_break = 1'b0;
		char_tick = 1'b0;
		tx_ready = 1'b0;
		tick_cnt = 0;
		stall = 0;
		grp_mode = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Character period ticks, free running like the line rate
	always @(posedge mclk) begin
		tick_cnt <= (tick_cnt == CHAR - 1) ? 0 : tick_cnt + 1;
		char_tick <= (tick_cnt == CHAR - 1);
	end

	////////////////////////////////////////////////////////////////////////////
	// One byte; the released line shows the inverse so no stale value lingers
	task automatic send(input logic [7:0] b);
		@(posedge mclk);
		rx_valid <= 1'b1;
		rx_data  <= b;
		@(posedge mclk);
		rx_valid <= 1'b0;
		rx_data  <= ~b;
		repeat (2) @(posedge mclk);
	endtask : send

	// Address, high byte first
	task automatic addr(input logic [15:0] a);
		send(a[15:8]);
		send(a[7:0]);
	endtask : addr

	// Line break pulse
	task automatic brk();
		@(posedge mclk);
		rx_break <= 1'b1;
		@(posedge mclk);
		rx_break <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask : brk

	// Break after own start so every tributary resynchronises
	task automatic power_on();
		brk();
	endtask : power_on

	// Count, message bytes, checksum; bad flips bit 0 of the checksum
	task automatic block(input logic [7:0] d[$], input bit bad);
		logic [7:0] s;
		s = 8'(d.size());
		send(`CH_STX);
		send(s);
		foreach (d[i]) begin
			send(d[i]);
			s = s + d[i];
		end
		send(8'(-s) ^ {7'h00, bad});
	endtask : block

	// Wait one reply; break when a needed reply stays away
	task automatic reply(input bit need, output logic [7:0] b, output bit got);
		int n;
		got = 1'b0;
		b = 8'h00;
		for (n = 0; n < 6 * CHAR && !got; n++) begin
			@(posedge mclk);
			got = tx_valid;
		end
		if (got) begin
			repeat (stall) @(posedge mclk);
			tx_ready <= 1'b1;
			@(posedge mclk);
			b = tx_data;
			tx_ready <= 1'b0;
			if (grp_mode && b == `CH_NAK) brk();
		end else if (need) brk();
	endtask : reply

	// Answer a received block, then hold for an exception reply
	task automatic ack_wait();
		send(`CH_ACK);
		repeat (6 * CHAR) @(posedge mclk);
	endtask : ack_wait

endmodule : bus_ctl_model

// file: testbench/tb.sv
// Self-checking testbench of the tributary protocol engine
`timescale 1ns/10ps
`include "trib_defines.svh"

module tb;
	import trib_pkg::*;
	localparam logic [15:0] SEL = 16'h8280;

	logic        mclk, reset, rx_valid, rx_break, char_tick, tx_valid, tx_ready;
	logic [7:0]  rx_data, tx_data, usr_rx_data, usr_tx_data;
	logic        usr_rx_valid, usr_rx_count, block_ready, block_error, usr_tx_valid;
	logic        usr_tx_ready, msg_pending, usr_busy, selected, group_selected, escape_mode;
	logic [15:0] select_addr;
	state_e      trib_state;
	logic [8:0]  ub[$];  // Bytes handed to the user, count flag on top
	int          errors, cmp_count, nrdy, nerr, cyc;

	always #20 mclk = ~mclk;

	tributary_select_protocol #(.TIMEOUT_CHARS(2)) i_dut (.mclk(mclk), .reset(reset),
		.select_addr(select_addr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_break(rx_break),
		.char_tick(char_tick), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.usr_rx_valid(usr_rx_valid), .usr_rx_data(usr_rx_data), .usr_rx_count(usr_rx_count),
		.block_ready(block_ready), .block_error(block_error), .usr_tx_valid(usr_tx_valid),
		.usr_tx_data(usr_tx_data), .usr_tx_ready(usr_tx_ready), .msg_pending(msg_pending),
		.usr_busy(usr_busy), .selected(selected), .group_selected(group_selected),
		.escape_mode(escape_mode), .trib_state(trib_state));

	bus_ctl_model #(.CHAR(8)) i_ctl (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_break(rx_break), .char_tick(char_tick), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready));

	////////////////////////////////////////////////////////////////////////////
	// User side monitor and run watchdog
	always @(posedge mclk) begin
		if (usr_rx_valid === 1'b1) ub.push_back({usr_rx_count, usr_rx_data});
		if (block_ready === 1'b1) nrdy++;
		if (block_error === 1'b1) nerr++;
		cyc++;
		if (cyc >= 20000) begin
			errors++;
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Reply as {got, byte}; 0000 means silence
	task automatic rp(input bit need, input logic [15:0] exp);
		logic [7:0] b;
		bit         got;
		i_ctl.reply(need, b, got);
		chk({7'h00, got, b}, exp);
	endtask : rp

	task automatic st(input state_e s);
		chk(16'(trib_state), 16'(s));
	endtask : st

	task automatic poll(input logic [15:0] exp);
		i_ctl.addr(SEL | 16'h0001);
		rp(1'b1, exp);
	endtask : poll

	task automatic sel_grp(input logic [7:0] b);
		i_ctl.power_on();
		i_ctl.addr(SEL);
		i_ctl.send(`CH_GROUP_ASSIGN);
		i_ctl.send(b);
		rp(1'b1, 16'h0104);
	endtask : sel_grp

	task automatic join_grp(input logic [15:0] a, input state_e s);
		i_ctl.power_on();
		i_ctl.addr(a);
		st(s);
	endtask : join_grp

	task automatic feed(input logic [7:0] d[$]);
		foreach (d[i]) begin
			usr_tx_valid <= 1'b1;
			usr_tx_data  <= d[i];
			@(posedge mclk);
			while (usr_tx_ready !== 1'b1) @(posedge mclk);
		end
		usr_tx_valid <= 1'b0;
	endtask : feed

	task automatic done(input string n);
		$display("test %s finished", n);
	endtask : done

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_power();
		int k;
		i_ctl.addr(SEL);
		st(ST_IDLE);
		i_ctl.power_on();
		st(ST_ACTIVE);
		poll(16'h0107);
		poll(16'h0104);
		// Pending alone, busy alone, both: busy outranks a service request
		for (k = 1; k < 4; k++) begin
			{usr_busy, msg_pending} <= 2'(k);
			poll((k == 1) ? 16'h0108 : 16'h0106);
		end
		{usr_busy, msg_pending} <= 2'b00;
		done("power");
	endtask : t_power

	task automatic t_rxblk();
		int n0, e0;
		i_ctl.power_on();
		i_ctl.addr(SEL);
		st(ST_SELECT);
		chk({13'h0000, selected, group_selected, escape_mode}, 16'h0004);
		n0 = nrdy;
		e0 = nerr;
		ub.delete();
		i_ctl.block('{8'h12, 8'hFE, 8'h80}, 1'b0);
		rp(1'b1, 16'h0104);
		chk(16'(nrdy - n0), 16'h0001);
		chk(16'(ub[0]), 16'h0103);
		chk(16'(ub[3]), 16'h0080);
		st(ST_SELECT);
		i_ctl.block('{8'h00}, 1'b1);
		rp(1'b1, 16'h0105);
		st(ST_IDLE);
		chk(16'(nerr - e0), 16'h0001);
		i_ctl.power_on();
		i_ctl.addr(16'h8380);
		st(ST_IDLE);
		// Another own address is honoured as configured
		select_addr <= SEL + 16'h0100;
		i_ctl.power_on();
		i_ctl.addr(16'h8380);
		st(ST_SELECT);
		select_addr <= SEL;
		done("rx_block");
	endtask : t_rxblk

	task automatic t_rxto();
		int e0;
		i_ctl.power_on();
		i_ctl.addr(SEL);
		e0 = nerr;
		i_ctl.send(`CH_STX);
		i_ctl.send(8'h02);
		i_ctl.send(8'h11);
		rp(1'b0, 16'h0000);
		st(ST_IDLE);
		chk(16'(nerr - e0), 16'h0001);
		i_ctl.power_on();
		i_ctl.addr(SEL);
		i_ctl.send(`CH_GROUP_ASSIGN);
		rp(1'b0, 16'h0000);
		st(ST_IDLE);
		i_ctl.power_on();
		poll(16'h0105);
		done("timeout");
	endtask : t_rxto

	task automatic t_group();
		int n0;
		sel_grp(8'h81);
		join_grp(16'h8082, ST_GSEL);
		chk({13'h0000, selected, group_selected, escape_mode}, 16'h0002);
		i_ctl.grp_mode = 1'b1;
		n0 = nrdy;
		i_ctl.block('{8'h5A}, 1'b0);
		rp(1'b0, 16'h0000);
		st(ST_GSEL);
		chk(16'(nrdy - n0), 16'h0001);
		i_ctl.block('{8'h5A}, 1'b1);
		rp(1'b0, 16'h0105);
		st(ST_ACTIVE);
		i_ctl.grp_mode = 1'b0;
		sel_grp(8'h01);
		join_grp(16'h8082, ST_IDLE);
		sel_grp(8'h80);
		join_grp(16'h81FE, ST_GSEL);
		// Mid-run reset drops every group but all-call
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		join_grp(16'h81FE, ST_IDLE);
		sel_grp(8'h00);
		join_grp(16'h81FE, ST_IDLE);
		join_grp(16'h8080, ST_GSEL);
		i_ctl.send(`CH_ESC);
		rp(1'b0, 16'h0000);
		st(ST_ESCMODE);
		done("group");
	endtask : t_group

	task automatic t_esc();
		i_ctl.power_on();
		i_ctl.addr(SEL);
		i_ctl.send(`CH_STX);
		i_ctl.send(8'h05);
		i_ctl.brk();
		st(ST_ACTIVE);
		i_ctl.addr(SEL);
		i_ctl.send(`CH_ESC);
		rp(1'b1, 16'h0104);
		ub.delete();
		i_ctl.send(`CH_STX);
		i_ctl.send(8'h9C);
		st(ST_ESCMODE);
		chk({13'h0000, selected, group_selected, escape_mode}, 16'h0005);
		chk(16'(ub[1]), 16'h009C);
		i_ctl.brk();
		st(ST_ACTIVE);
		done("escape");
	endtask : t_esc

	task automatic t_tx();
		int         k;
		logic [7:0] e[4];
		e = '{8'h02, 8'hA1, 8'hB2, 8'h00};
		e[3] = 8'(-(e[0] + e[1] + e[2]));
		i_ctl.power_on();
		i_ctl.addr(SEL);
		i_ctl.stall = 3;
		i_ctl.send(`CH_TRANSMIT_EN);
		fork
			feed('{e[0], e[1], e[2]});
			for (k = 0; k < 4; k++) rp(1'b1, {8'h01, e[k]});
		join
		i_ctl.ack_wait();
		st(ST_SELECT);
		done("transmit");
	endtask : t_tx

	////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	initial begin
		mclk = 1'b0;
		reset = 1'b1;
		select_addr = SEL;
		usr_tx_valid = 1'b0;
		usr_tx_data = 8'h00;
		msg_pending = 1'b0;
		usr_busy = 1'b0;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		t_power();
		t_rxblk();
		t_rxto();
		t_group();
		t_esc();
		t_tx();
		close_out();
	end

endmodule : tb
